// file: logic/tpd_tap_detect.v
// Tap detection: thresholds, time limit, latency and source register
`timescale 1ns/1ps
`include "tpd_regs.vh"
module tpd_tap_detect (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Register port
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  // Sample stream, signed 8g-scaled samples at 0.063g per count
  input wire sampleStep,
  input wire signed [11:0] accelX,
  input wire signed [11:0] accelY,
  input wire signed [11:0] accelZ,
  // Mode inputs
  input wire low_noise_low_power_mode,
  input wire tap_lowpass_on,
  // Interrupt to pin logic
  output reg tapIrq
);
  // ============================================================
  // Configuration registers
  reg [7:0] tapCfg_reg;
  reg [6:0] thrX_reg;
  reg [6:0] thrY_reg;
  reg [6:0] thrZ_reg;
  reg [7:0] tap_time_limit_field_reg;
  reg [7:0] tap_latency_field_reg;
  reg [7:0] tap_source_reg;
  reg [7:0] tap_source_next;
  wire flag_latch_on = tapCfg_reg[`TPD_CFG_LATCH];
  wire srcRead = regRead && (regAddr == `TPD_ADDR_SRC);

  // Write strobes; unmapped addresses hit none of them
  wire wrCfg = regWrite && (regAddr == `TPD_ADDR_CFG);
  wire wrThX = regWrite && (regAddr == `TPD_ADDR_THX);
  wire wrThY = regWrite && (regAddr == `TPD_ADDR_THY);
  wire wrThZ = regWrite && (regAddr == `TPD_ADDR_THZ);
  wire wrTml = regWrite && (regAddr == `TPD_ADDR_TML);
  wire wrLat = regWrite && (regAddr == `TPD_ADDR_LAT);

  // One register per process, each with its own reset value
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      tapCfg_reg <= `TPD_RST_8;
    else if (wrCfg)
      tapCfg_reg <= regWdata;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      thrX_reg <= 7'h00;
    else if (wrThX)
      thrX_reg <= regWdata[6:0];
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      thrY_reg <= 7'h00;
    else if (wrThY)
      thrY_reg <= regWdata[6:0];
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      thrZ_reg <= 7'h00;
    else if (wrThZ)
      thrZ_reg <= regWdata[6:0];
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      tap_time_limit_field_reg <= `TPD_RST_8;
    else if (wrTml)
      tap_time_limit_field_reg <= regWdata;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      tap_latency_field_reg <= `TPD_RST_8;
    else if (wrLat)
      tap_latency_field_reg <= regWdata;
  end

  // ============================================================
  // Threshold compare
  // Low-noise caps the effective threshold at half scale
  function [6:0] effThr;
    input [6:0] thr;
    input lowNoise;
    begin
      if (lowNoise && thr > `TPD_THS_MAX_LOWNOISE)
        effThr = `TPD_THS_MAX_LOWNOISE;
      else
        effThr = thr;
    end
  endfunction

  function [11:0] absVal;
    input signed [11:0] v;
    begin
      absVal = v[11] ? (~v + 12'h001) : v;
    end
  endfunction

  wire [6:0] effX = effThr(thrX_reg, low_noise_low_power_mode);
  wire [6:0] effY = effThr(thrY_reg, low_noise_low_power_mode);
  wire [6:0] effZ = effThr(thrZ_reg, low_noise_low_power_mode);
  wire [2:0] over;
  assign over[0] = absVal(accelX) > {5'h00, effX};
  assign over[1] = absVal(accelY) > {5'h00, effY};
  assign over[2] = absVal(accelZ) > {5'h00, effZ};
  wire [2:0] sgn = {accelZ[11], accelY[11], accelX[11]};

  // ============================================================
  // Step divider: filter on halves the step at the same data rate
  reg stepPhase_reg;
  reg stepEn;
  always @* begin
    stepEn = sampleStep && (tap_lowpass_on ? stepPhase_reg : 1'b1);
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      stepPhase_reg <= 1'b0;
    else if (sampleStep)
      stepPhase_reg <= ~stepPhase_reg;
  end

  // ============================================================
  // Tap state machine
  localparam ST_IDLE = 2'h0;
  localparam ST_PULSE = 2'h1;
  localparam ST_LAT = 2'h2;
  localparam ST_WAIT2 = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg [2:0] axes_reg;
  reg [2:0] axes_next;
  reg [2:0] sign_reg;
  reg [2:0] sign_next;
  reg second_reg;
  reg second_next;
  reg [2:0] overSeen_reg;

  reg [2:0] evAxes;
  reg evValid;
  reg evDouble;
  // Only a crossing starts a tap, so a held level cannot retrigger
  wire [2:0] rising = over & ~overSeen_reg;

  // Saturating step counter, never wraps past the longest interval
  function [7:0] bump;
    input [7:0] c;
    begin
      if (c == `TPD_STEP_MAX)
        bump = c;
      else
        bump = c + 8'h01;
    end
  endfunction

  // ============================================================
  // Next-state logic
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    axes_next = axes_reg;
    sign_next = sign_reg;
    second_next = second_reg;

    case (state_reg)
      ST_IDLE: begin
        if (|rising) begin
          state_next = ST_PULSE;
          cnt_next = 8'h00;
          axes_next = rising;
          sign_next = sgn;
          second_next = 1'b0;
        end
      end

      ST_PULSE: begin
        if (~|(over & axes_reg)) begin
          state_next = ST_LAT;
          cnt_next = 8'h00;
        end else if (cnt_reg >= tap_time_limit_field_reg ||
                     cnt_reg == `TPD_STEP_MAX) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = bump(cnt_reg);
        end
      end

      ST_LAT: begin
        if (cnt_reg >= tap_latency_field_reg) begin
          state_next = second_reg ? ST_IDLE : ST_WAIT2;
          cnt_next = 8'h00;
        end else begin
          cnt_next = bump(cnt_reg);
        end
      end

      ST_WAIT2: begin
        if (|rising) begin
          state_next = ST_PULSE;
          cnt_next = 8'h00;
          second_next = 1'b1;
        end else if (cnt_reg >= tap_latency_field_reg) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = bump(cnt_reg);
        end
      end

      default: state_next = ST_IDLE;
    endcase
  end

  // Only the step enable moves the machine
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      axes_reg <= 3'h0;
      sign_reg <= 3'h0;
      second_reg <= 1'b0;
      overSeen_reg <= 3'h0;
    end else if (stepEn) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      axes_reg <= axes_next;
      sign_reg <= sign_next;
      second_reg <= second_next;
      overSeen_reg <= over;
    end
  end

  // Enable masks in Z, Y, X order to line up with the axis bits
  wire [2:0] singleEn = {tapCfg_reg[4], tapCfg_reg[2], tapCfg_reg[0]};
  wire [2:0] doubleEn = {tapCfg_reg[5], tapCfg_reg[3], tapCfg_reg[1]};

  // Event is the accepted pulse end; single on first, double on second
  always @* begin
    evValid = stepEn && (state_reg == ST_PULSE) && ~|(over & axes_reg) &&
              ~(cnt_reg > tap_time_limit_field_reg);
    evDouble = second_reg;
    evAxes = axes_reg & (evDouble ? doubleEn : singleEn);
  end

  // ============================================================
  // Source register, clear on read, event set wins over read clear
  always @* begin
    tap_source_next = srcRead ? `TPD_RST_8 : tap_source_reg;
    if (evValid && (|evAxes)) begin
      tap_source_next[`TPD_SRC_EA] = 1'b1;
      if (!(flag_latch_on && tap_source_reg[`TPD_SRC_EA] && !srcRead)) begin
        tap_source_next[6:4] = evAxes;
        tap_source_next[`TPD_SRC_DPE] = evDouble;
        tap_source_next[2:0] = sign_reg & evAxes;
      end
    end else if (!flag_latch_on && !tap_source_reg[`TPD_SRC_EA]) begin
      tap_source_next[6:0] = 7'h00;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_source_reg <= `TPD_RST_8;
      tapIrq <= 1'b0;
    end else begin
      tap_source_reg <= tap_source_next;
      tapIrq <= tap_source_next[`TPD_SRC_EA];
    end
  end

  // ============================================================
  // Read data
  // Mux first, then one flop, so the output stays registered
  reg [7:0] rdNext;
  always @* begin
    rdNext = 8'h00;
    case (regAddr)
      `TPD_ADDR_CFG: rdNext = tapCfg_reg;
      `TPD_ADDR_SRC: rdNext = tap_source_reg;
      `TPD_ADDR_THX: rdNext = {1'b0, thrX_reg};
      `TPD_ADDR_THY: rdNext = {1'b0, thrY_reg};
      `TPD_ADDR_THZ: rdNext = {1'b0, thrZ_reg};
      `TPD_ADDR_TML: rdNext = tap_time_limit_field_reg;
      `TPD_ADDR_LAT: rdNext = tap_latency_field_reg;
      default: rdNext = 8'h00;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      regRdata <= `TPD_RST_8;
    else if (regRead)
      regRdata <= rdNext;
  end
endmodule // tpd_tap_detect

// file: logic/tpd_regs.vh
// Register map, field positions, reset values and timing for tap detection
`ifndef TPD_REGS_VH
`define TPD_REGS_VH
`define TPD_ADDR_CFG 8'h21
`define TPD_ADDR_SRC 8'h22
`define TPD_ADDR_THX 8'h23
`define TPD_ADDR_THY 8'h24
`define TPD_ADDR_THZ 8'h25
`define TPD_ADDR_TML 8'h26
`define TPD_ADDR_LAT 8'h27
`define TPD_RST_8 8'h00
`define TPD_CFG_LATCH 6
`define TPD_SRC_EA 7
`define TPD_SRC_DPE 3
`define TPD_THS_MAX_LOWNOISE 7'h40
`define TPD_STEP_MAX 8'hFF
`endif

// file: test/tpd_tap_detect_checker.sv
// Port checker for the tap detection block
`timescale 1ns/1ps
module tpd_checker (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Register port
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  // Samples and modes
  input wire sampleStep,
  input wire signed [11:0] accelX,
  input wire signed [11:0] accelY,
  input wire signed [11:0] accelZ,
  input wire low_noise_low_power_mode,
  input wire tap_lowpass_on,
  input wire tapIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire srcRd = regRead && regAddr == 8'h22;
  // ==========
  // Assertions
  AST_EA_READ: assert property (srcRd |=>
    regRdata[7] == $past(tapIrq)) else $error("flag read wrong");
  AST_AXIS_SET: assert property (srcRd && tapIrq |=>
    regRdata[6:4] != 3'b000) else $error("no axis bit");
  AST_HOLD: assert property (tapIrq && !srcRd |=>
    tapIrq) else $error("irq dropped early");
  AST_CLEAR: assert property (srcRd && !tapIrq |=>
    regRdata == 8'h00) else $error("idle source not zero");
  // Same-step events win over the clear, so skip them
  AST_IRQ_OFF: assert property (
    srcRd && !sampleStep && !$past(sampleStep) |=> !tapIrq)
    else $error("irq not cleared");
  AST_BIT7: assert property (
    regRead && regAddr >= 8'h23 && regAddr <= 8'h25 |=> !regRdata[7])
    else $error("threshold bit 7 set");
  AST_ON_STEP: assert property ($rose(tapIrq) |->
    $past(sampleStep, 1) || $past(sampleStep, 2)) else $error("off step");
  AST_RESET: assert property ($rose(reset_n) |->
    !tapIrq && regRdata == 8'h00) else $error("reset state wrong");
  CV_READ: cover property (srcRd && tapIrq);
  CV_NOISE: cover property ($rose(tapIrq) && low_noise_low_power_mode);
  CV_LPF: cover property ($rose(tapIrq) && tap_lowpass_on);
endmodule // tpd_checker
bind tpd_tap_detect tpd_checker i_tpd_checker (.*);

// file: test/tpd_sample_src.sv
// Sample source model feeding the tap detector
`timescale 1ns/1ps
module tpd_sample_src #(
  parameter PERIOD = 4
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Wanted acceleration
  input wire signed [11:0] wantX,
  input wire signed [11:0] wantY,
  input wire signed [11:0] wantZ,
  // Sample stream
  output reg sampleStep,
  output reg signed [11:0] accelX,
  output reg signed [11:0] accelY,
  output reg signed [11:0] accelZ
);
  reg [7:0] cnt_reg;
  wire last = cnt_reg == PERIOD - 1;
  // ==========
  // Data only moves on a step, as a real converter would
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 8'h00;
      sampleStep <= 1'b0;
      {accelX, accelY, accelZ} <= 36'h0;
    end else begin
      cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
      sampleStep <= last;
      if (last) {accelX, accelY, accelZ} <= {wantX, wantY, wantZ};
    end
  end
endmodule // tpd_sample_src

// file: test/test_tpd_tap_detect.sv
// Self-checking bench for the tap detection block
`timescale 1ns/1ps
module test_tpd_tap_detect;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [7:0] regWdata = 8'h00;
  reg lowNoise = 1'b0;
  reg lowPass = 1'b0;
  reg signed [11:0] wantX = 12'h000;
  reg signed [11:0] wantY = 12'h000;
  reg signed [11:0] wantZ = 12'h000;
  wire [7:0] regRdata;
  wire sampleStep;
  wire tapIrq;
  wire signed [11:0] accelX;
  wire signed [11:0] accelY;
  wire signed [11:0] accelZ;
  integer miscompares = 0;
  integer comparisons = 0;
  integer i;
  always #4 clk = ~clk;
  tpd_sample_src i_tpd_sample_src (.clk(clk), .reset_n(reset_n),
    .wantX(wantX), .wantY(wantY), .wantZ(wantZ), .sampleStep(sampleStep),
    .accelX(accelX), .accelY(accelY), .accelZ(accelZ));
  tpd_tap_detect i_tpd_tap_detect (.clk(clk), .reset_n(reset_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .sampleStep(sampleStep),
    .accelX(accelX), .accelY(accelY), .accelZ(accelZ),
    .low_noise_low_power_mode(lowNoise), .tap_lowpass_on(lowPass),
    .tapIrq(tapIrq));
  task end_of_test;
    begin
      if (miscompares == 0 && comparisons > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 cmp(regRdata, exp);
    end
  endtask
  // Bounded: a stalled step source ends the run
  task steps(input integer n);
    integer k, seen;
    begin
      seen = 0;
      for (k = 0; k < 400 && seen < n; k = k + 1) begin
        @(negedge clk);
        if (sampleStep === 1'b1) seen = seen + 1;
      end
      if (seen < n) begin
        miscompares = miscompares + 1;
        end_of_test;
      end
    end
  endtask
  task tap(input signed [11:0] x, y, z, input integer n, gap);
    begin
      @(posedge clk);
      {wantX, wantY, wantZ} <= {x, y, z};
      steps(n);
      @(posedge clk);
      {wantX, wantY, wantZ} <= 36'h0;
      steps(gap);
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 8'h23; i <= 8'h27; i = i + 1) rd(i[7:0], 8'h00);
    wr(8'h23, 8'hFF);
    rd(8'h23, 8'h7F);
    wr(8'h23, 8'h10);
    wr(8'h24, 8'h20);
    wr(8'h25, 8'h30);
    wr(8'h26, 8'h08);
    wr(8'h27, 8'h03);
    wr(8'h21, 8'h15);
    tap(12'sd32, 0, 0, 2, 10);
    rd(8'h22, 8'h90);
    cmp({7'h00, tapIrq}, 8'h00);
    rd(8'h22, 8'h00);
    tap(0, 0, -12'sd64, 2, 10);
    rd(8'h22, 8'hC4);
    tap(0, 12'sd32, 0, 2, 10);
    rd(8'h22, 8'h00);
    tap(12'sd32, 0, 0, 12, 10);
    rd(8'h22, 8'h00);
    lowPass <= 1'b1;
    tap(12'sd32, 0, 0, 12, 20);
    rd(8'h22, 8'h90);
    lowPass <= 1'b0;
    wr(8'h21, 8'h01);
    tap(0, 12'sd48, 0, 2, 10);
    rd(8'h22, 8'h00);
    wr(8'h21, 8'h55);
    tap(12'sd32, 0, 0, 2, 10);
    tap(0, 0, -12'sd64, 2, 10);
    rd(8'h22, 8'h90);
    wr(8'h21, 8'h15);
    tap(12'sd32, 0, 0, 2, 10);
    tap(0, 0, -12'sd64, 2, 10);
    rd(8'h22, 8'hC4);
    wr(8'h21, 8'h02);
    tap(12'sd32, 0, 0, 2, 5);
    tap(12'sd32, 0, 0, 2, 10);
    rd(8'h22, 8'h98);
    wr(8'h21, 8'h15);
    wr(8'h23, 8'h7F);
    lowNoise <= 1'b1;
    tap(12'sd80, 0, 0, 2, 10);
    rd(8'h22, 8'h90);
    end_of_test;
  end
endmodule // test_tpd_tap_detect
